// *** src/spcc_regs.svh ***
// register offsets, field positions, reset values and timing values in nanoseconds of the channel control
`ifndef SPCC_REGS_SVH
`define SPCC_REGS_SVH

`define SPCC_CTRL_OFS 8'h00
`define SPCC_MODE_OFS 8'h04
`define SPCC_DIR_OFS 8'h08
`define SPCC_STAT_OFS 8'h0C
`define SPCC_PINS_OFS 8'h10
`define SPCC_ISTAT_OFS 8'h14
`define SPCC_IMASK_OFS 8'h18
`define SPCC_PDSIZE_BASE 8'h20

`define SPCC_CTRL_APPLY_BIT 0
`define SPCC_PDSIZE_SWAP_BIT 7
`define SPCC_STAT_SWAP_LSB 8
`define SPCC_STAT_INIT_BIT 16
`define SPCC_IRQ_APPLY_BIT 8

`define SPCC_PDSIZE_RST 8'h01
`define SPCC_MODE_RST 8'h00
`define SPCC_DIR_RST 16'h0000
`define SPCC_IMASK_RST 9'h000

`define SPCC_CLK_PERIOD_NS 10
`define SPCC_LOSS_TIME_NS 1000000

`endif

// *** src/spcc_pkg.sv ***
// types shared by the sensor port channel control
package spcc_pkg;

   typedef enum logic [1:0] {
      SPCC_PIN_INPUT,
      SPCC_PIN_OUTPUT,
      SPCC_PIN_SMART
   } spcc_pin_cfg_type;

   typedef struct packed {
      logic [15:0] word;
      logic valid;
   } spcc_pd_type;

endpackage

// *** src/spcc_top.sv ***
// per-channel control: link loss detection, byte swap, pin mode selection, apb registers
`timescale 1ns/1ps
`default_nettype none
`include "spcc_regs.svh"

// Operation
// - in smart-link mode a lost link clears that channel's communication-started flag, eight flags.
// - loss detection always runs on every smart-link channel with no enable or setting.
// - with swap enabled, both bytes of each process data word are exchanged in both directions.
// - the swap enable is bit seven of the channel's process data size value.
// - a swap change after initial processing is loaded only on the apply-settings request.
// - each of the eight channels selects smart-link or switching mode, sixteen pins in all.
// - after reset every channel is in switching mode as an input.
// - in switching mode a pin only sources current, it never sinks.
// - each switching input pin reports its on/off state on its remote input bit.
// - a direction change after initial processing is loaded only on the apply-settings request.
// - each of a port's two pins has its own value; the first is input, output or smart-link, the second only input or output.
module spcc_top import spcc_pkg::*; #(
   parameter int unsigned LOSS_CYCLES = `SPCC_LOSS_TIME_NS / `SPCC_CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq,
   // link status from the channel transceivers
   input wire logic [7:0] link_frame_ok,
   output logic [7:0] link_comm_started_flags,
   // process data
   input wire spcc_pd_type [7:0] dev_in_pd,
   output spcc_pd_type [7:0] host_in_pd,
   input wire spcc_pd_type [7:0] host_out_pd,
   output spcc_pd_type [7:0] dev_out_pd,
   // network bits
   input wire logic [15:0] remote_output_bits,
   output logic [15:0] remote_input_bits,
   // port pins
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe,
   output spcc_pin_cfg_type [15:0] pin_cfg
);

   function automatic logic [15:0] swap_bytes(input logic en, input logic [15:0] w);
      swap_bytes = en ? {w[7:0], w[15:8]} : w;
   endfunction

   // software-facing state
   logic apply_settings_request;
   logic apply_q;
   logic init_phase;
   logic [7:0] pend_smart;
   logic [15:0] pin_direction_select_cmds;
   logic [7:0] pd_size [8];
   logic [8:0] irq_status;
   logic [8:0] irq_mask;

   // applied configuration
   logic [7:0] act_smart;
   logic [15:0] act_dir;
   logic [7:0] act_swap;

   // link supervision
   logic [19:0] silence_cnt [8];
   logic [7:0] comm_flag;

   // pin synchroniser
   logic [15:0] pin_s1;
   logic [15:0] pin_s2;
   logic [15:0] pin_s3;
   logic [15:0] pin_state;

   // bus decode
   wire setup_phase = psel & ~penable;
   wire wr_en = psel & penable & pready & pwrite;
   wire aligned = (paddr[1:0] == 2'b00);
   wire hit_ctrl = aligned & (paddr == `SPCC_CTRL_OFS);
   wire hit_mode = aligned & (paddr == `SPCC_MODE_OFS);
   wire hit_dir = aligned & (paddr == `SPCC_DIR_OFS);
   wire hit_stat = aligned & (paddr == `SPCC_STAT_OFS);
   wire hit_pins = aligned & (paddr == `SPCC_PINS_OFS);
   wire hit_istat = aligned & (paddr == `SPCC_ISTAT_OFS);
   wire hit_imask = aligned & (paddr == `SPCC_IMASK_OFS);
   wire hit_pds = aligned & (paddr[7:5] == 3'(`SPCC_PDSIZE_BASE >> 5));
   wire [2:0] pds_idx = paddr[4:2];
   wire hit_any = hit_ctrl | hit_mode | hit_dir | hit_stat | hit_pins | hit_istat
                  | hit_imask | hit_pds;

   // pending swap bits gathered from the size values
   logic [7:0] pend_swap;
   always_comb begin
      for (int c = 0; c < 8; c++) begin
         pend_swap[c] = pd_size[c][`SPCC_PDSIZE_SWAP_BIT];
      end
   end

   wire [31:0] stat_word = {15'h0000, init_phase, act_swap, comm_flag};
   wire [31:0] rd_mux =
      hit_ctrl ? {31'h0000_0000, apply_settings_request} :
      hit_mode ? {24'h00_0000, pend_smart} :
      hit_dir ? {16'h0000, pin_direction_select_cmds} :
      hit_stat ? stat_word :
      hit_pins ? {16'h0000, remote_input_bits} :
      hit_istat ? {23'h00_0000, irq_status} :
      hit_imask ? {23'h00_0000, irq_mask} :
      hit_pds ? {24'h00_0000, pd_size[pds_idx]} :
      32'h0000_0000;

   // answer in the cycle after setup, so every access costs exactly two cycles
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_phase;
         prdata <= setup_phase ? rd_mux : 32'h0000_0000;
         pslverr <= setup_phase & ~hit_any;
      end
   end

   // configuration writes
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         apply_settings_request <= 1'b0;
         pend_smart <= `SPCC_MODE_RST;
         pin_direction_select_cmds <= `SPCC_DIR_RST;
         irq_mask <= `SPCC_IMASK_RST;
         for (int c = 0; c < 8; c++) begin
            pd_size[c] <= `SPCC_PDSIZE_RST;
         end
      end else if (wr_en) begin
         if (hit_ctrl) begin
            apply_settings_request <= pwdata[`SPCC_CTRL_APPLY_BIT];
         end
         if (hit_mode) begin
            pend_smart <= pwdata[7:0];
         end
         if (hit_dir) begin
            pin_direction_select_cmds <= pwdata[15:0];
         end
         if (hit_imask) begin
            irq_mask <= pwdata[8:0];
         end
         if (hit_pds) begin
            pd_size[pds_idx] <= pwdata[7:0];
         end
      end
   end

   // apply request: edge taken, all pending settings move together
   wire apply_rise = apply_settings_request & ~apply_q;
   wire load_cfg = init_phase | apply_rise;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         apply_q <= 1'b0;
         init_phase <= 1'b1;
         act_smart <= `SPCC_MODE_RST;
         act_dir <= `SPCC_DIR_RST;
         act_swap <= 8'h00;
      end else begin
         apply_q <= apply_settings_request;
         if (apply_rise) begin
            init_phase <= 1'b0;
         end
         // during initial processing the settings follow software directly
         if (load_cfg) begin
            act_smart <= pend_smart;
            act_dir <= pin_direction_select_cmds;
            act_swap <= pend_swap;
         end
      end
   end

   // link loss supervision, no enable on purpose
   wire [7:0] timed_out;
   wire [7:0] lost_evt;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_sup
         assign timed_out[g] = (32'(silence_cnt[g]) >= LOSS_CYCLES - 1);
         assign lost_evt[g] = act_smart[g] & comm_flag[g] & ~link_frame_ok[g]
                              & timed_out[g];
      end
   endgenerate

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         comm_flag <= 8'h00;
         for (int c = 0; c < 8; c++) begin
            silence_cnt[c] <= 20'h0_0000;
         end
      end else begin
         for (int c = 0; c < 8; c++) begin
            if (!act_smart[c] || link_frame_ok[c] || lost_evt[c]) begin
               silence_cnt[c] <= 20'h0_0000;
               comm_flag[c] <= act_smart[c] & link_frame_ok[c];
            end else if (comm_flag[c]) begin
               silence_cnt[c] <= silence_cnt[c] + 20'h0_0001;
            end
         end
      end
   end

   // interrupt status, a new event beats a clear in the same cycle
   wire [8:0] irq_events = {apply_rise, lost_evt};
   wire [8:0] irq_clear = (wr_en & hit_istat) ? pwdata[8:0] : 9'h000;
   wire [8:0] next_irq_status = (irq_status & ~irq_clear) | irq_events;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_status <= 9'h000;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_mask);
      end
   end

   // pin synchroniser: a change counts when stages two and three agree
   wire [15:0] next_pin_state = (pin_s2 & pin_s3) | (pin_state & (pin_s2 | pin_s3));

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1 <= 16'h0000;
         pin_s2 <= 16'h0000;
         pin_s3 <= 16'h0000;
         pin_state <= 16'h0000;
      end else begin
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_state <= next_pin_state;
      end
   end

   // pin configuration: the first pin of a port carries the smart link, the second stays free
   spcc_pin_cfg_type next_pin_cfg [16];
   logic [15:0] is_in;
   logic [15:0] is_out;
   always_comb begin
      for (int p = 0; p < 16; p++) begin
         if (act_smart[p / 2] && (p % 2 == 0)) begin
            next_pin_cfg[p] = SPCC_PIN_SMART;
         end else if (act_dir[p]) begin
            next_pin_cfg[p] = SPCC_PIN_OUTPUT;
         end else begin
            next_pin_cfg[p] = SPCC_PIN_INPUT;
         end
         is_in[p] = (next_pin_cfg[p] == SPCC_PIN_INPUT);
         is_out[p] = (next_pin_cfg[p] == SPCC_PIN_OUTPUT);
      end
   end

   // source-type driver: the pin is only ever pulled high, never low
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_out <= 16'h0000;
         pin_oe <= 16'h0000;
         remote_input_bits <= 16'h0000;
         for (int p = 0; p < 16; p++) begin
            pin_cfg[p] <= SPCC_PIN_INPUT;
         end
      end else begin
         pin_out <= is_out & remote_output_bits;
         pin_oe <= is_out & remote_output_bits;
         remote_input_bits <= is_in & pin_state;
         for (int p = 0; p < 16; p++) begin
            pin_cfg[p] <= next_pin_cfg[p];
         end
      end
   end

   // process data paths with optional byte exchange
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         host_in_pd <= '0;
         dev_out_pd <= '0;
         link_comm_started_flags <= 8'h00;
      end else begin
         link_comm_started_flags <= comm_flag;
         for (int c = 0; c < 8; c++) begin
            host_in_pd[c].word <= swap_bytes(act_swap[c], dev_in_pd[c].word);
            host_in_pd[c].valid <= dev_in_pd[c].valid;
            dev_out_pd[c].word <= swap_bytes(act_swap[c], host_out_pd[c].word);
            dev_out_pd[c].valid <= host_out_pd[c].valid;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_apply_edge;
      !apply_settings_request ##1 apply_settings_request;
   endsequence

   chk_flag_loss_cause: assert property (
      $fell(comm_flag[0]) |-> $past(lost_evt[0]) || !$past(act_smart[0]))
      else $error("comm flag fell without loss or mode exit");
   chk_loss_always_on: assert property (
      act_smart[0] && comm_flag[0] && !link_frame_ok[0] && timed_out[0] |=> !comm_flag[0])
      else $error("loss not detected on timeout");
   chk_swap_in_data: assert property (
      act_swap[2] && $stable(act_swap[2])
      |=> host_in_pd[2].word == {$past(dev_in_pd[2].word[7:0]), $past(dev_in_pd[2].word[15:8])})
      else $error("input word not swapped");
   chk_swap_bit_seven: assert property (
      apply_rise |=> act_swap == $past(pend_swap))
      else $error("swap not taken from bit seven");
   chk_swap_hold: assert property (
      !init_phase && !apply_rise |=> $stable(act_swap))
      else $error("swap changed without apply");
   chk_dir_hold: assert property (
      !init_phase && !apply_rise |=> $stable(act_dir) && $stable(act_smart))
      else $error("direction changed without apply");
   chk_source_only: assert property (
      pin_oe[3] |-> pin_out[3] && pin_cfg[3] == SPCC_PIN_OUTPUT && $past(remote_output_bits[3]))
      else $error("pin driven low");
   chk_remote_input: assert property (
      is_in[4] |=> remote_input_bits[4] == $past(pin_state[4]))
      else $error("input bit not reported");
   chk_apply_edge: assert property (
      s_apply_edge |=> !init_phase && irq_status[`SPCC_IRQ_APPLY_BIT])
      else $error("apply edge did not end initial processing");
   chk_pin_cfg_pair: assert property (
      act_smart[5] && $stable(act_smart) |=> pin_cfg[10] == SPCC_PIN_SMART)
      else $error("smart pin not configured");

endmodule
`default_nettype wire

// *** tb/spcc_sensor_model.sv ***
// smart sensor stand-in: periodic frames and process data on every channel
`timescale 1ns/1ps
`default_nettype none
module spcc_sensor_model import spcc_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // bench control, one bit a channel
   input wire logic [7:0] alive,
   // link side
   output logic [7:0] link_frame_ok,
   output spcc_pd_type [7:0] dev_in_pd
);
   logic [2:0] tick;
   logic frame;
   assign frame = (tick == 3'h0);
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick <= 3'h0;
         link_frame_ok <= 8'h00;
         dev_in_pd <= '0;
      end else begin
         tick <= tick + 3'h1;
         for (int c = 0; c < 8; c++) begin
            link_frame_ok[c] <= alive[c] && frame;
            dev_in_pd[c].valid <= alive[c] && frame;
            // between frames the word keeps toggling so a stale copy never matches
            dev_in_pd[c].word <= (alive[c] && frame) ? 16'($urandom) : ~dev_in_pd[c].word;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/test_spcc_top.sv ***
// self-checking bench of the channel control against a behavioural model
`timescale 1ns/1ps
`default_nettype none
`include "spcc_regs.svh"
module test_spcc_top import spcc_pkg::*; ;
   logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, err, chk_pd;
   logic [7:0] paddr, alive, link_frame_ok, link_comm_started_flags;
   logic [7:0] pend_mode, act_mode, pend_swap, act_swap;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] remote_output_bits, remote_input_bits, pin_in, pin_out, pin_oe;
   logic [15:0] pend_dir, act_dir, in_mask, out_mask;
   spcc_pd_type [7:0] dev_in_pd, host_in_pd, host_out_pd, dev_out_pd, prev_in, prev_out;
   spcc_pin_cfg_type [15:0] pin_cfg;
   int mismatches, compares, cycles;

   // short loss time keeps the run brief
   spcc_top #(.LOSS_CYCLES(20)) i_spcc_top (.core_clk, .sys_rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .link_frame_ok,
      .link_comm_started_flags, .dev_in_pd, .host_in_pd, .host_out_pd, .dev_out_pd,
      .remote_output_bits, .remote_input_bits, .pin_in, .pin_out, .pin_oe, .pin_cfg);
   spcc_sensor_model i_spcc_sensor_model (.core_clk, .sys_rst, .alive, .link_frame_ok,
      .dev_in_pd);

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tally_and_finish();
      if (mismatches == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // request held from setup until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      // no fixed wait: only the bench timeout ends a hung access
      do begin
         @(posedge core_clk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   function automatic logic [1:0] exp_cfg(int i);
      if (i % 2 == 0 && act_mode[i / 2]) return SPCC_PIN_SMART;
      return act_dir[i] ? SPCC_PIN_OUTPUT : SPCC_PIN_INPUT;
   endfunction

   function automatic spcc_pd_type sw(spcc_pd_type d, logic s);
      sw = d;
      if (s) sw.word = {d.word[7:0], d.word[15:8]};
   endfunction

   task automatic pins();
      pin_in <= 16'($urandom);
      remote_output_bits <= 16'($urandom);
      repeat (8) @(posedge core_clk);
      for (int i = 0; i < 16; i++) begin
         chk("pin_cfg", 32'(exp_cfg(i)), 32'(pin_cfg[i]));
         in_mask[i] = (exp_cfg(i) == SPCC_PIN_INPUT);
         out_mask[i] = (exp_cfg(i) == SPCC_PIN_OUTPUT);
      end
      chk("remote_input_bits", 32'(pin_in & in_mask), 32'(remote_input_bits));
      chk("pin_out", 32'(remote_output_bits & out_mask), 32'(pin_out));
      chk("pin_oe", 32'(remote_output_bits & out_mask), 32'(pin_oe));
   endtask

   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end

   // data in both directions checked every cycle while chk_pd is set; host side data is fresh each cycle
   always @(posedge core_clk) begin
      for (int c = 0; c < 8; c++) begin
         if (chk_pd) begin
            chk("host_in_pd", 32'(sw(prev_in[c], act_swap[c])), 32'(host_in_pd[c]));
            chk("dev_out_pd", 32'(sw(prev_out[c], act_swap[c])), 32'(dev_out_pd[c]));
         end
         host_out_pd[c] <= {16'($urandom), 1'($urandom)};
      end
      prev_in = dev_in_pd;
      prev_out = host_out_pd;
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial begin
      void'($urandom(86));
      {sys_rst, psel, penable, pwrite, paddr, pwdata, chk_pd} = {1'h1, 44'h0};
      {remote_output_bits, pin_in} = '0;
      alive = 8'hFF;
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'h0;
      @(posedge core_clk);
      {act_mode, act_dir} = '0;
      for (int i = 0; i < 16; i++) chk("pin_cfg reset", 32'(SPCC_PIN_INPUT), 32'(pin_cfg[i]));
      apb(1'h0, `SPCC_PDSIZE_BASE + 8'h1C, 32'h0);
      chk("pdsize reset", 32'h0000_0001, rd);
      apb(1'h0, 8'h1C, 32'h0);
      chk("unmapped error", 32'h0000_0001, 32'(err));
      // swap and directions are set in initial processing, before data matters
      for (int c = 0; c < 8; c++) begin
         pend_swap[c] = 1'($urandom);
         apb(1'h1, `SPCC_PDSIZE_BASE + 8'(4 * c), {24'h0, pend_swap[c], 7'h01});
      end
      pend_mode = (8'($urandom) | 8'h21) & 8'hFD;
      pend_dir = 16'($urandom);
      apb(1'h1, `SPCC_MODE_OFS, 32'(pend_mode));
      apb(1'h1, `SPCC_DIR_OFS, 32'(pend_dir));
      apb(1'h1, `SPCC_CTRL_OFS, 32'h0000_0001);
      {act_mode, act_dir, act_swap} = {pend_mode, pend_dir, pend_swap};
      repeat (30) @(posedge core_clk);
      apb(1'h0, `SPCC_STAT_OFS, 32'h0);
      chk("stat", {15'h0, 1'h0, act_swap, act_mode}, rd);
      chk_pd = 1'h1;
      repeat (3) pins();
      alive <= 8'hFE;
      repeat (40) @(posedge core_clk);
      chk("comm flags", 32'(act_mode & 8'hFE), 32'(link_comm_started_flags));
      apb(1'h0, `SPCC_ISTAT_OFS, 32'h0);
      chk("irq status", 32'h0000_0101, rd);
      chk("irq masked", 32'h0, 32'(irq));
      apb(1'h1, `SPCC_IMASK_OFS, 32'h0000_0001);
      repeat (2) @(posedge core_clk);
      chk("irq raised", 32'h0000_0001, 32'(irq));
      apb(1'h1, `SPCC_ISTAT_OFS, 32'h0000_0101);
      repeat (2) @(posedge core_clk);
      chk("irq cleared", 32'h0, 32'(irq));
      // later changes wait for a fresh apply edge
      pend_dir = ~pend_dir;
      pend_swap = ~pend_swap;
      for (int c = 0; c < 8; c++) apb(1'h1, `SPCC_PDSIZE_BASE + 8'(4 * c), {24'h0, pend_swap[c], 7'h01});
      apb(1'h1, `SPCC_DIR_OFS, 32'(pend_dir));
      pins();
      apb(1'h1, `SPCC_CTRL_OFS, 32'h0);
      chk_pd = 1'h0;
      apb(1'h1, `SPCC_CTRL_OFS, 32'h0000_0001);
      {act_dir, act_swap} = {pend_dir, pend_swap};
      repeat (4) @(posedge core_clk);
      chk_pd = 1'h1;
      repeat (2) pins();
      tally_and_finish();
   end
endmodule
`default_nettype wire
